// >>> design/twmsl_host_master.sv
// Two-wire bus master that drives the device's slave unit over its open-drain pins.
// Assumes pins are resolved outside as wired-AND; one command is one byte.
`timescale 1ns/100ps
module twmsl_host_master
    import twmsl_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       fast_in,
    input  wire logic       cmd_valid_in,
    output logic            cmd_ready_out,
    input  wire logic       cmd_start_in,
    input  wire logic       cmd_stop_in,
    input  wire logic       cmd_read_in,
    input  wire logic       cmd_ack_in,
    input  wire logic [7:0] cmd_wdata_in,
    output logic            rsp_valid_out,
    output logic [7:0]      rsp_rdata_out,
    output logic            rsp_nack_out,
    output logic            rsp_arb_lost_out,
    output logic            bus_busy_out,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe_out,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out
);
    twmsl_state_t state_r;
    twmsl_state_t state_nxt;
    logic         q_r;
    logic         q_nxt;
    logic [3:0]   bit_r;
    logic [3:0]   bit_nxt;
    logic [7:0]   shift_r;
    logic [7:0]   shift_nxt;
    logic [7:0]   wbyte_r;
    logic [7:0]   wbyte_nxt;
    logic [7:0]   rx_r;
    logic [7:0]   rx_nxt;
    logic         read_r;
    logic         read_nxt;
    logic         stop_r;
    logic         stop_nxt;
    logic         ack_r;
    logic         ack_nxt;
    logic         nack_r;
    logic         nack_nxt;
    logic         scl_oe_r;
    logic         scl_oe_nxt;
    logic         sda_oe_r;
    logic         sda_oe_nxt;
    logic         rsp_valid_r;
    logic         rsp_valid_nxt;
    logic         arb_r;
    logic         arb_nxt;
    logic         busy_r;
    logic         busy_nxt;
    logic         scl_prev_r;
    logic         sda_prev_r;
    logic [1:0]   lines;
    logic         scl_s;
    logic         sda_s;
    logic         tick;
    logic         tick_clr;
    logic         start_det;
    logic         stop_det;
    logic         take;

    twmsl_pin_sync u_sync (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .pins_in    ({scl_in, sda_in}),
        .pins_out   (lines)
    );
    assign scl_s = lines[1];
    assign sda_s = lines[0];

    twmsl_tick_gen u_tick (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .fast_in    (fast_in),
        .clr_in     (tick_clr),
        .tick_out   (tick)
    );

    // Bus monitor: own START/STOP count too, so a waiting start sees the line free after our own STOP
    assign start_det = scl_s && scl_prev_r && sda_prev_r && !sda_s;
    assign stop_det  = scl_s && scl_prev_r && !sda_prev_r && sda_s;

    always_comb
    begin
        busy_nxt = busy_r;
        if (start_det)
        begin
            busy_nxt = 1'b1;
        end
        else if (stop_det)
        begin
            busy_nxt = 1'b0;
        end
    end

    assign take          = cmd_valid_in && cmd_ready_out;
    assign cmd_ready_out = (state_r == ST_IDLE) || (state_r == ST_HOLD);
    // Phase timing restarts on each move and while someone holds the clock low
    assign tick_clr = (state_nxt != state_r) || (state_r == ST_HIGH_WAIT) || (state_r == ST_RS_HIGH && !scl_s)
                    || (state_r == ST_STOP_HIGH && !scl_s);

    always_comb
    begin
        state_nxt     = state_r;
        q_nxt         = q_r;
        bit_nxt       = bit_r;
        shift_nxt     = shift_r;
        wbyte_nxt     = wbyte_r;
        rx_nxt        = rx_r;
        read_nxt      = read_r;
        stop_nxt      = stop_r;
        ack_nxt       = ack_r;
        nack_nxt      = nack_r;
        scl_oe_nxt    = scl_oe_r;
        sda_oe_nxt    = sda_oe_r;
        rsp_valid_nxt = 1'b0;
        arb_nxt       = 1'b0;
        if (take)
        begin
            // Direction lives in the address byte; read flag picks the bit engine
            shift_nxt = cmd_wdata_in;
            wbyte_nxt = cmd_wdata_in;
            read_nxt  = cmd_read_in;
            stop_nxt  = cmd_stop_in;
            ack_nxt   = cmd_ack_in;
            bit_nxt   = 4'h0;
            q_nxt     = 1'b0;
        end
        unique case (state_r)
            ST_IDLE:
            begin
                if (take)
                begin
                    state_nxt = ST_WAIT_FREE;
                end
            end
            ST_WAIT_FREE:
            begin
                if (scl_s && sda_s && !busy_r)
                begin
                    state_nxt  = ST_START;
                    sda_oe_nxt = 1'b1;
                end
            end
            ST_START:
            begin
                if (tick)
                begin
                    // Repeated START arrives with the quarter flag set; first bit must still be driven
                    state_nxt  = ST_LOW;
                    scl_oe_nxt = 1'b1;
                    q_nxt      = 1'b0;
                end
            end
            ST_LOW:
            begin
                if (tick && !q_r)
                begin
                    // Data moves only a quarter after the clock fell
                    q_nxt = 1'b1;
                    if (bit_r == ACK_BIT)
                    begin
                        sda_oe_nxt = read_r && ack_r;
                    end
                    else if (read_r)
                    begin
                        sda_oe_nxt = 1'b0;
                    end
                    else
                    begin
                        sda_oe_nxt = !shift_r[7];
                        shift_nxt  = {shift_r[6:0], 1'b0};
                    end
                end
                else if (tick)
                begin
                    state_nxt  = ST_HIGH_WAIT;
                    scl_oe_nxt = 1'b0;
                end
            end
            ST_HIGH_WAIT:
            begin
                if (scl_s)
                begin
                    state_nxt = ST_HIGH;
                    q_nxt     = 1'b0;
                end
            end
            ST_HIGH:
            begin
                if (tick && !q_r)
                begin
                    q_nxt = 1'b1;
                    if (bit_r == ACK_BIT && !read_r)
                    begin
                        nack_nxt = sda_s;
                    end
                    else if (bit_r != ACK_BIT && read_r)
                    begin
                        rx_nxt = {rx_r[6:0], sda_s};
                    end
                    else if (bit_r != ACK_BIT && !sda_oe_r && !sda_s)
                    begin
                        // Sent a one, saw a zero: another master owns the bus
                        state_nxt  = ST_LOST;
                        sda_oe_nxt = 1'b0;
                        arb_nxt    = 1'b1;
                    end
                end
                else if (tick)
                begin
                    scl_oe_nxt = 1'b1;
                    q_nxt      = 1'b0;
                    if (bit_r == ACK_BIT)
                    begin
                        rsp_valid_nxt = 1'b1;
                        if (stop_r || (nack_r && !read_r))
                        begin
                            state_nxt = ST_STOP_LOW;
                        end
                        else
                        begin
                            state_nxt = ST_HOLD;
                        end
                    end
                    else
                    begin
                        state_nxt = ST_LOW;
                        bit_nxt   = bit_r + 4'h1;
                    end
                end
            end
            ST_HOLD:
            begin
                // Clock kept low between bytes; any byte count is allowed
                if (take && cmd_start_in)
                begin
                    state_nxt = ST_RS_LOW;
                end
                else if (take)
                begin
                    state_nxt = ST_LOW;
                end
            end
            ST_RS_LOW:
            begin
                if (tick && !q_r)
                begin
                    q_nxt      = 1'b1;
                    sda_oe_nxt = 1'b0;
                end
                else if (tick)
                begin
                    state_nxt  = ST_RS_HIGH;
                    scl_oe_nxt = 1'b0;
                end
            end
            ST_RS_HIGH:
            begin
                if (tick && scl_s)
                begin
                    state_nxt  = ST_START;
                    sda_oe_nxt = 1'b1;
                end
            end
            ST_STOP_LOW:
            begin
                if (tick && !q_r)
                begin
                    q_nxt      = 1'b1;
                    sda_oe_nxt = 1'b1;
                end
                else if (tick)
                begin
                    state_nxt  = ST_STOP_HIGH;
                    scl_oe_nxt = 1'b0;
                end
            end
            ST_STOP_HIGH:
            begin
                if (tick && scl_s)
                begin
                    state_nxt  = ST_STOP_END;
                    sda_oe_nxt = 1'b0;
                end
            end
            ST_STOP_END:
            begin
                if (tick)
                begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_LOST:
            begin
                scl_oe_nxt = 1'b0;
                sda_oe_nxt = 1'b0;
                if (!busy_r && scl_s && sda_s)
                begin
                    state_nxt = ST_IDLE;
                end
            end
            default:
            begin
                state_nxt  = ST_IDLE;
                scl_oe_nxt = 1'b0;
                sda_oe_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            state_r     <= ST_IDLE;
            q_r         <= 1'b0;
            bit_r       <= 4'h0;
            shift_r     <= 8'h00;
            wbyte_r     <= 8'h00;
            rx_r        <= 8'h00;
            read_r      <= 1'b0;
            stop_r      <= 1'b0;
            ack_r       <= 1'b0;
            nack_r      <= 1'b0;
            scl_oe_r    <= 1'b0;
            sda_oe_r    <= 1'b0;
            rsp_valid_r <= 1'b0;
            arb_r       <= 1'b0;
            busy_r      <= 1'b0;
            scl_prev_r  <= 1'b1;
            sda_prev_r  <= 1'b1;
        end
        else
        begin
            state_r     <= state_nxt;
            q_r         <= q_nxt;
            bit_r       <= bit_nxt;
            shift_r     <= shift_nxt;
            wbyte_r     <= wbyte_nxt;
            rx_r        <= rx_nxt;
            read_r      <= read_nxt;
            stop_r      <= stop_nxt;
            ack_r       <= ack_nxt;
            nack_r      <= nack_nxt;
            scl_oe_r    <= scl_oe_nxt;
            sda_oe_r    <= sda_oe_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            arb_r       <= arb_nxt;
            busy_r      <= busy_nxt;
            scl_prev_r  <= scl_s;
            sda_prev_r  <= sda_s;
        end
    end

    assign scl_out          = 1'b0;
    assign sda_out          = 1'b0;
    assign scl_oe_out       = scl_oe_r;
    assign sda_oe_out       = sda_oe_r;
    assign rsp_valid_out    = rsp_valid_r;
    assign rsp_rdata_out    = rx_r;
    assign rsp_nack_out     = nack_r;
    assign rsp_arb_lost_out = arb_r;
    assign bus_busy_out     = busy_r;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    chk_sda_hold_high: assert property ((state_r == ST_HIGH && state_nxt == ST_HIGH) |=> $stable(sda_oe_r))
        else $error("data line moved while clock high");
    chk_start_shape: assert property ((sda_oe_r && !$past(sda_oe_r) && !scl_oe_r) |-> state_r == ST_START)
        else $error("data pulled low under high clock outside START");
    chk_stop_shape: assert property (($fell(sda_oe_r) && !scl_oe_r) |-> state_r inside {ST_STOP_END, ST_LOST})
        else $error("data released under high clock outside STOP");
    chk_msb_first: assert property ((state_r == ST_HIGH && !read_r && bit_r < ACK_BIT)
                                    |-> sda_oe_r == !wbyte_r[3'(4'h7 - bit_r)])
        else $error("write bit not in MSB-first order");
    chk_ack_release: assert property ((state_r == ST_HIGH && bit_r == ACK_BIT && !read_r) |-> !sda_oe_r)
        else $error("transmitter held data in ack slot");
    chk_ack_drive: assert property ((state_r == ST_HIGH && bit_r == ACK_BIT && read_r) |-> sda_oe_r == ack_r)
        else $error("receiver ack does not follow request");
    chk_byte_nine: assert property (rsp_valid_r |-> bit_r == ACK_BIT && $past(state_r) == ST_HIGH)
        else $error("byte ended before ninth clock");
    chk_stretch_wait: assert property ((state_r == ST_HIGH_WAIT && !scl_s) |=> state_r == ST_HIGH_WAIT)
        else $error("clock stretch not honoured");
    chk_idle_start: assert property ((state_r == ST_WAIT_FREE && state_nxt == ST_START)
                                     |-> scl_s && sda_s && !busy_r)
        else $error("START on a bus not idle");
    chk_nack_stop: assert property ((rsp_valid_r && nack_r && !read_r) |-> state_r == ST_STOP_LOW)
        else $error("no STOP after missing ack");
    chk_busy_track: assert property (start_det |=> busy_r)
        else $error("START not seen by bus monitor");
    chk_lost_release: assert property (arb_r |-> state_r == ST_LOST ##1 (!sda_oe_r && !scl_oe_r))
        else $error("lines not freed after lost arbitration");

    cov_write_byte: cover property (rsp_valid_r && !read_r && !nack_r);
    cov_read_byte: cover property (rsp_valid_r && read_r);
    cov_arb_lost: cover property (arb_r);
    cov_stretch: cover property (state_r == ST_HIGH_WAIT && !scl_s ##8 state_r == ST_HIGH_WAIT);
endmodule

// >>> design/twmsl_pkg.sv
// Constants, state codes and timing counts for the two-wire bus master controller.
// Assumes a 10 MHz system clock and open-drain pads resolved outside the design.
// Rules of the two-wire bus
// - Bus idle only when both lines high
// - Nine clocks per byte, ack included
// - Bytes MSB first, unlimited per transfer
// - Receiver may stretch clock; transmitter waits
// - START/STOP are data edges under clock high
// - First byte: seven-bit address plus direction
// - Direction zero writes, one reads
// - Data stable while clock high
// - Transmitter releases data during ack
// - Receiver acknowledges by pulling data low
// - Unaccepted address: data high, master stops
// - Slave releases data after missing ack
package twmsl_pkg;

    localparam int unsigned CLK_HZ   = 10_000_000;
    localparam int unsigned STD_BPS  = 100_000;
    localparam int unsigned FAST_BPS = 400_000;

    // Quarter bit period, rounded down; the wait for the clock to rise still makes each bit a few clocks longer than asked
    localparam logic [4:0] QTR_STD  = 5'(CLK_HZ / (4 * STD_BPS));
    localparam logic [4:0] QTR_FAST = 5'(CLK_HZ / (4 * FAST_BPS));

    localparam logic [3:0] ACK_BIT  = 4'h8;
    localparam logic [1:0] LINE_RST = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_WAIT_FREE = 4'h1,
        ST_START     = 4'h2,
        ST_LOW       = 4'h3,
        ST_HIGH_WAIT = 4'h4,
        ST_HIGH      = 4'h5,
        ST_HOLD      = 4'h6,
        ST_RS_LOW    = 4'h7,
        ST_RS_HIGH   = 4'h8,
        ST_STOP_LOW  = 4'h9,
        ST_STOP_HIGH = 4'ha,
        ST_STOP_END  = 4'hb,
        ST_LOST      = 4'hc
    } twmsl_state_t;

endpackage

// >>> design/twmsl_pin_sync.sv
// Three-stage synchroniser with agreement filter for the two bus lines.
// Assumes asynchronous pin inputs; lines are taken as high (idle) during reset.
`timescale 1ns/100ps
module twmsl_pin_sync
    import twmsl_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       sys_rst_in,
    input  wire logic [1:0] pins_in,
    output logic      [1:0] pins_out
);
    logic [1:0] s1_r;
    logic [1:0] s2_r;
    logic [1:0] s3_r;
    logic [1:0] flt_r;
    logic [1:0] flt_nxt;

    always_comb
    begin
        flt_nxt = flt_r;
        for (int i = 0; i < 2; i++)
        begin
            if (s2_r[i] == s3_r[i])
            begin
                flt_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            s1_r  <= LINE_RST;
            s2_r  <= LINE_RST;
            s3_r  <= LINE_RST;
            flt_r <= LINE_RST;
        end
        else
        begin
            s1_r  <= pins_in;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            flt_r <= flt_nxt;
        end
    end

    assign pins_out = flt_r;
endmodule

// >>> design/twmsl_tick_gen.sv
// Quarter-bit tick generator for the bus clock.
// Assumes the caller clears it on every phase change and while the clock is held low.
`timescale 1ns/100ps
module twmsl_tick_gen
    import twmsl_pkg::*;
(
    input  wire logic mclk_in,
    input  wire logic sys_rst_in,
    input  wire logic fast_in,
    input  wire logic clr_in,
    output logic      tick_out
);
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [4:0] last;

    always_comb
    begin
        last     = (fast_in ? QTR_FAST : QTR_STD) - 5'h01;
        tick_out = (cnt_r == last);
        if (clr_in || tick_out)
        begin
            cnt_nxt = 5'h00;
        end
        else
        begin
            cnt_nxt = cnt_r + 5'h01;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            cnt_r <= 5'h00;
        end
        else
        begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// >>> tb/twmsl_slave_model.sv
// Behavioural two-wire slave with one byte of storage, far side of the master.
// Assumes wired-AND lines with pull-ups resolved by the bench.
`timescale 1ns/100ps
module twmsl_slave_model #(
    parameter logic [6:0] ADDR       = 7'h2a,
    parameter int         STRETCH_NS = 8000
)(
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       stretch_in,
    output logic            scl_oe_out,
    output logic            sda_oe_out,
    output logic [7:0]      mem_out
);
    logic [7:0] sh_r = 8'h00;
    logic [7:0] tx_r = 8'h00;
    logic       act_r = 0, adr_r = 0, sel_r = 0, rd_r = 0, snd_r = 0, mack_r = 0;
    int         bitn = 0;

    initial
    begin
        scl_oe_out = 0;
        sda_oe_out = 0;
        mem_out = 8'h00;
    end

    always @(negedge sda_in)
    begin
        if (scl_in === 1'b1)
        begin
            act_r = 1;
            adr_r = 1;
            sel_r = 0;
            snd_r = 0;
            sda_oe_out = 0;
            bitn = -1;
        end
    end

    always @(posedge sda_in)
    begin
        if (scl_in === 1'b1)
        begin
            act_r = 0;
            snd_r = 0;
        end
    end

    always @(posedge scl_in)
    begin
        if (act_r && !snd_r && bitn >= 0 && bitn < 8)
            sh_r = {sh_r[6:0], sda_in};
        if (snd_r && bitn == 8)
            mack_r = !sda_in;
    end

    // Changes lag the falling clock so they never look like START or STOP
    always @(negedge scl_in)
    begin
        if (act_r)
        begin
            bitn = bitn + 1;
            #150;
            if (bitn == 8)
            begin
                if (snd_r)
                    sda_oe_out = 0;
                else if (adr_r)
                begin
                    sel_r = (sh_r[7:1] == ADDR);
                    rd_r = sh_r[0];
                    sda_oe_out = sel_r;
                end
                else
                begin
                    if (sel_r)
                        mem_out = sh_r;
                    sda_oe_out = sel_r;
                end
            end
            else if (bitn == 9)
            begin
                bitn = 0;
                snd_r = sel_r && rd_r && (adr_r || mack_r);
                adr_r = 0;
                tx_r = mem_out;
                sda_oe_out = snd_r && !tx_r[7];
                if (stretch_in)
                begin
                    scl_oe_out = 1;
                    #(STRETCH_NS);
                    scl_oe_out = 0;
                end
            end
            else if (snd_r)
                sda_oe_out = !tx_r[7 - bitn];
        end
    end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the two-wire master against a slave model.
// Assumes wired-AND lines with pull-ups built here; 10 MHz system clock.
`timescale 1ns/100ps
module testbench;
    import twmsl_pkg::*;
    localparam logic [6:0] SLV = 7'h2a;
    logic       mclk_in, sys_rst_in, fast_in, cmd_valid_in, cmd_start_in, cmd_stop_in;
    logic       cmd_read_in, cmd_ack_in, cmd_ready_out, rsp_valid_out, rsp_nack_out;
    logic       rsp_arb_lost_out, bus_busy_out, m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe;
    logic       tb_sda_oe, stretch, got_arb, got_nack, m_scl_o, m_sda_o;
    logic [7:0] cmd_wdata_in, rsp_rdata_out, smem, got_rd;
    wire        scl_w = !(m_scl_oe | s_scl_oe);
    wire        sda_w = !(m_sda_oe | s_sda_oe | tb_sda_oe);
    int         bad_count = 0, compares = 0;
    realtime    last_rise = 0, period = 0, per = 0;

    twmsl_host_master dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .fast_in(fast_in),
        .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_start_in(cmd_start_in),
        .cmd_stop_in(cmd_stop_in), .cmd_read_in(cmd_read_in), .cmd_ack_in(cmd_ack_in),
        .cmd_wdata_in(cmd_wdata_in), .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
        .rsp_nack_out(rsp_nack_out), .rsp_arb_lost_out(rsp_arb_lost_out), .bus_busy_out(bus_busy_out),
        .scl_in(scl_w), .scl_out(m_scl_o), .scl_oe_out(m_scl_oe), .sda_in(sda_w), .sda_out(m_sda_o),
        .sda_oe_out(m_sda_oe));
    twmsl_slave_model #(.ADDR(SLV)) slv (.scl_in(scl_w), .sda_in(sda_w), .stretch_in(stretch),
        .scl_oe_out(s_scl_oe), .sda_oe_out(s_sda_oe), .mem_out(smem));

    initial
    begin
        mclk_in = 0;
        forever #50 mclk_in = ~mclk_in;
    end

    always @(posedge scl_w)
    begin
        period = $realtime - last_rise;
        last_rise = $realtime;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One byte: offer until taken, then wait for its answer
    task automatic do_cmd(input logic s, input logic p, input logic r, input logic a, input logic [7:0] d);
        int n;
        @(posedge mclk_in);
        cmd_valid_in <= 1;
        cmd_start_in <= s;
        cmd_stop_in <= p;
        cmd_read_in <= r;
        cmd_ack_in <= a;
        cmd_wdata_in <= d;
        n = 0;
        do
        begin
            @(negedge mclk_in);
            n++;
        end while (cmd_ready_out !== 1'b1 && n < 5000);
        @(posedge mclk_in);
        cmd_valid_in <= 0;
        n = 0;
        do
        begin
            @(negedge mclk_in);
            n++;
        end while (rsp_valid_out !== 1'b1 && rsp_arb_lost_out !== 1'b1 && n < 5000);
        got_arb = rsp_arb_lost_out;
        got_nack = rsp_nack_out;
        got_rd = rsp_rdata_out;
        per = period;
        chk("byte answered", 1'b1, rsp_valid_out | rsp_arb_lost_out);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (!(cmd_ready_out === 1'b1 && bus_busy_out === 1'b0) && n < 3000)
        begin
            @(negedge mclk_in);
            n++;
        end
        chk("bus free", 1'b0, bus_busy_out);
    endtask

    task automatic t_reset();
        chk("ready", 1'b1, cmd_ready_out);
        chk("busy", 1'b0, bus_busy_out);
        chk("lines released", 2'b00, {m_scl_oe, m_sda_oe});
        chk("pin drive value", 2'b00, {m_scl_o, m_sda_o});
        $display("test reset done");
    endtask

    task automatic t_write();
        do_cmd(1, 0, 0, 0, {SLV, 1'b0});
        chk("addr ack", 1'b0, got_nack);
        chk("busy mid", 1'b1, bus_busy_out);
        chk("std period", 1'b1, per >= 400 * QTR_STD && per <= 400 * QTR_STD + 1000);
        do_cmd(0, 1, 0, 0, 8'ha5);
        chk("data ack", 1'b0, got_nack);
        wait_idle();
        chk("slave byte", 8'ha5, smem);
        $display("test write done");
    endtask

    task automatic t_read_stretch();
        stretch = 1;
        do_cmd(1, 0, 0, 0, {SLV, 1'b1});
        chk("addr ack", 1'b0, got_nack);
        do_cmd(0, 0, 1, 1, 8'h00);
        chk("read 1", 8'ha5, got_rd);
        do_cmd(0, 1, 1, 0, 8'h00);
        chk("read 2", 8'ha5, got_rd);
        wait_idle();
        stretch = 0;
        $display("test read_stretch done");
    endtask

    task automatic t_nack();
        do_cmd(1, 0, 0, 0, {7'h11, 1'b0});
        chk("addr nack", 1'b1, got_nack);
        wait_idle();
        $display("test nack done");
    endtask

    task automatic t_rstart();
        @(posedge mclk_in);
        fast_in <= 1;
        do_cmd(1, 0, 0, 0, {SLV, 1'b0});
        do_cmd(0, 0, 0, 0, 8'h3c);
        chk("fast period", 1'b1, per >= 400 * QTR_FAST && per <= 400 * QTR_FAST + 1000);
        do_cmd(1, 0, 0, 0, {SLV, 1'b1});
        chk("rs addr ack", 1'b0, got_nack);
        do_cmd(0, 1, 1, 0, 8'h00);
        chk("rs read", 8'h3c, got_rd);
        wait_idle();
        @(posedge mclk_in);
        fast_in <= 0;
        $display("test rstart done");
    endtask

    // Another master holds data low under our first released bit
    task automatic t_arb();
        fork
            do_cmd(1, 1, 0, 0, 8'hff);
            begin
                @(negedge scl_w);
                @(posedge mclk_in);
                tb_sda_oe <= 1;
            end
        join
        chk("arb lost", 1'b1, got_arb);
        repeat (20) @(negedge mclk_in);
        chk("loser off", 2'b00, {m_scl_oe, m_sda_oe});
        chk("busy held", 1'b1, bus_busy_out);
        @(posedge mclk_in);
        tb_sda_oe <= 0;
        wait_idle();
        $display("test arb done");
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #5_000_000;
        bad_count++;
        $display("ERROR watchdog expected done seen hang");
        tally_and_finish();
    end

    initial
    begin
        {sys_rst_in, fast_in, cmd_valid_in, cmd_start_in, cmd_stop_in} = 5'h10;
        {cmd_read_in, cmd_ack_in, tb_sda_oe, stretch} = 4'h0;
        cmd_wdata_in = 8'h00;
        repeat (10) @(posedge mclk_in);
        sys_rst_in <= 0;
        @(negedge mclk_in);
        t_reset();
        t_write();
        t_read_stretch();
        t_nack();
        t_rstart();
        t_arb();
        tally_and_finish();
    end
endmodule
